/* dbcc_pkg.sv */
`default_nettype none

package dbcc_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int CODE_W    = 12;
  localparam int NUM_CH    = 8;
  localparam int CH_W      = 3;
  localparam int CAL_W     = 16;
  localparam int CAL_IDX_W = 6;
  localparam int ADDR_W    = 12;
  localparam int DATA_W    = 32;

  // ****************************************************************
  // Address map
  // ****************************************************************
  localparam logic [6:0] BOARD_PATTERN = 7'h10;
  localparam logic [1:0] REG_CMD       = 2'h0;
  localparam logic [1:0] REG_SHIFT     = 2'h1;
  localparam logic [1:0] REG_CAL_IDX   = 2'h2;
  localparam logic [1:0] REG_CAL_DATA  = 2'h3;

  // ****************************************************************
  // Field positions
  // ****************************************************************
  localparam int CMD_INIT_BIT  = 0;
  localparam int CMD_SW_BIT    = 1;
  localparam int CMD_STATE_BIT = 2;
  localparam int SH_DATA_BIT   = 0;
  localparam int SH_CH_LSB     = 1;

  // ****************************************************************
  // Reset values and counts
  // ****************************************************************
  localparam logic [CODE_W-1:0]    CODE_RST    = 12'h000;
  localparam logic [CAL_W-1:0]     CAL_RST     = 16'h0000;
  localparam logic [CAL_IDX_W-1:0] CAL_IDX_RST = 6'h00;
  localparam logic [NUM_CH-1:0]    EN_RST      = 8'h00;
  localparam logic [3:0]           CNT_RST     = 4'h0;
  localparam logic [3:0]           CNT_LAST    = 4'hb;
  localparam logic [DATA_W-1:0]    RDATA_RST   = 32'h0000_0000;

  typedef enum logic [0:0] {
    DBCC_IDLE = 1'b0,
    DBCC_ACK  = 1'b1
  } dbcc_bus_t;

  function automatic logic dbcc_board_hit(input logic [ADDR_W-1:0] addr,
                                          input logic [CH_W-1:0]   board);
    return (addr[11:5] == BOARD_PATTERN) && (addr[4:2] == board);
  endfunction

  function automatic logic dbcc_cal_local(input logic [CAL_IDX_W-1:0] idx,
                                          input logic [CH_W-1:0]      board);
    return idx[CAL_IDX_W-1:CH_W] == board;
  endfunction

endpackage

`default_nettype wire

/* dbcc_core_if.sv */
`default_nettype none

interface dbcc_core_if;
  import dbcc_pkg::*;

  logic              bit_valid;
  logic              bit_in;
  logic [CH_W-1:0]   bit_ch;
  logic              abort;
  logic              load;
  logic [CODE_W-1:0] load_code;
  logic [CH_W-1:0]   load_ch;
  logic [3:0]        fill_cnt;
  logic              cal_we;
  logic [CH_W-1:0]   cal_idx;
  logic [CAL_W-1:0]  cal_wdata;
  logic [CAL_W-1:0]  cal_rdata;

  modport ctrl  (output bit_valid, bit_in, bit_ch, abort, cal_we, cal_idx, cal_wdata,
                 input  load, load_code, load_ch, fill_cnt, cal_rdata);
  modport shift (input  bit_valid, bit_in, bit_ch, abort,
                 output load, load_code, load_ch, fill_cnt);
  modport cal   (input  cal_we, cal_idx, cal_wdata,
                 output cal_rdata);
endinterface

`default_nettype wire

/* dbcc_shifter.sv */
`default_nettype none

module dbcc_shifter (
  input wire logic   ref_clk,
  input wire logic   nrst,
  dbcc_core_if.shift sif
);
  import dbcc_pkg::*;

  logic [CODE_W-1:0] sreg_q;
  logic [CODE_W-1:0] code_q;
  logic [CH_W-1:0]   ch_q;
  logic [3:0]        cnt_q;
  logic              load_q;
  logic              last_bit;

  assign last_bit = sif.bit_valid && (cnt_q == CNT_LAST) && !sif.abort;

  always_ff @(posedge ref_clk) begin
    if (!nrst || sif.abort) begin
      cnt_q <= CNT_RST;
    end else if (sif.bit_valid) begin
      cnt_q <= (cnt_q == CNT_LAST) ? CNT_RST : cnt_q + 4'h1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sreg_q <= CODE_RST;
    end else if (sif.bit_valid) begin
      sreg_q <= {sreg_q[CODE_W-2:0], sif.bit_in};
    end
  end

  // The code leaves only when all twelve bits are in.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      load_q <= 1'b0;
      code_q <= CODE_RST;
      ch_q   <= '0;
    end else begin
      load_q <= last_bit;
      if (last_bit) begin
        code_q <= {sreg_q[CODE_W-2:0], sif.bit_in};
        ch_q   <= sif.bit_ch;
      end
    end
  end

  assign sif.load      = load_q;
  assign sif.load_code = code_q;
  assign sif.load_ch   = ch_q;
  assign sif.fill_cnt  = cnt_q;
endmodule

`default_nettype wire

/* dbcc_calib.sv */
`default_nettype none

module dbcc_calib (
  input wire logic ref_clk,
  input wire logic por_n,
  dbcc_core_if.cal cif
);
  import dbcc_pkg::*;

  logic [CAL_W-1:0] rec_q [NUM_CH];

  // Records survive the bus reset; only power-on clears them.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_rec
    always_ff @(posedge ref_clk) begin
      if (!por_n) begin
        rec_q[i] <= CAL_RST;
      end else if (cif.cal_we && (cif.cal_idx == CH_W'(i))) begin
        rec_q[i] <= cif.cal_wdata;
      end
    end
  end

  assign cif.cal_rdata = rec_q[cif.cal_idx];
endmodule

`default_nettype wire

/* dbcc_top.sv */
`default_nettype none

// Summary of operation
// - Bus reset never disturbs codes, enables or reference; only commands, completed channel loads and power-on change them.
// - Initialisation tristates every converter so each channel sits near 0 V.
// - Switch state nonzero turns reference on; zero tristates converters, reference zero.
// - The switch command acts on every channel of the board together.
// - First code loaded after initialisation or switching enables that channel.
// - A channel whose converter is off delivers zero at the amplifier stage.
// - Each channel write carries a 12-bit unsigned code that becomes the level while the reference is on.
// - Global channel is eight times board number plus channel number.
// - Bits shift serially into the input register, then move to the output register.
// - Switching reference on turns converters off; outputs may briefly rise toward 2 V.
// - One calibration record per channel, read and written by global index 0 to 63.
// - Board answers pattern 0010000, three jumper bits, two register select bits.

module dbcc_top (
  input  wire logic                                           ref_clk,
  input  wire logic                                           nrst,
  input  wire logic                                           por_n,
  input  wire logic [dbcc_pkg::CH_W-1:0]                      board_sel,
  input  wire logic                                           four_ch_variant,
  input  wire logic [dbcc_pkg::ADDR_W-1:0]                    avs_address,
  input  wire logic                                           avs_read,
  input  wire logic                                           avs_write,
  input  wire logic [dbcc_pkg::DATA_W-1:0]                    avs_writedata,
  output var  logic [dbcc_pkg::DATA_W-1:0]                    avs_readdata,
  output var  logic                                           avs_waitrequest,
  output var  logic [dbcc_pkg::NUM_CH-1:0][dbcc_pkg::CODE_W-1:0] dac_code,
  output var  logic [dbcc_pkg::NUM_CH-1:0]                    dac_out_en,
  output var  logic                                           ref_on,
  output var  logic [dbcc_pkg::NUM_CH-1:0][dbcc_pkg::CODE_W-1:0] chan_level
);
  import dbcc_pkg::*;

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  dbcc_bus_t                         st_q;
  logic [DATA_W-1:0]                 rdata_q;
  logic [CAL_IDX_W-1:0]              cal_idx_q;
  logic [NUM_CH-1:0]                 en_q;
  logic                              ref_q;
  logic [NUM_CH-1:0][CODE_W-1:0]     code_q;
  logic [NUM_CH-1:0][CODE_W-1:0]     level_q;
  logic                              hit;
  logic [1:0]                        reg_sel;
  logic                              wr_fire;
  logic                              init_fire;
  logic                              sw_fire;
  logic                              sw_state;
  logic                              load_ok;
  logic [DATA_W-1:0]                 rd_mux;

  dbcc_core_if core ();

  assign hit     = dbcc_board_hit(avs_address, board_sel);
  assign reg_sel = avs_address[1:0];

  // Every access, mapped or not, is answered one cycle after it is raised.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_q <= DBCC_IDLE;
    end else begin
      unique case (st_q)
        DBCC_IDLE: begin
          if (avs_read || avs_write) begin
            st_q <= DBCC_ACK;
          end
        end
        DBCC_ACK: begin
          st_q <= DBCC_IDLE;
        end
      endcase
    end
  end

  assign avs_waitrequest = (avs_read || avs_write) && (st_q != DBCC_ACK);

  always_comb begin
    rd_mux = RDATA_RST;
    if (hit) begin
      unique case (reg_sel)
        REG_CMD:      rd_mux = {22'h0, four_ch_variant, ref_q, en_q};
        REG_SHIFT:    rd_mux = {25'h0, core.load_ch, core.fill_cnt};
        REG_CAL_IDX:  rd_mux = {26'h0, cal_idx_q};
        REG_CAL_DATA: rd_mux = dbcc_cal_local(cal_idx_q, board_sel) ?
                               {16'h0, core.cal_rdata} : RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_q <= RDATA_RST;
    end else if ((st_q == DBCC_IDLE) && avs_read) begin
      rdata_q <= rd_mux;
    end
  end

  assign avs_readdata = rdata_q;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  assign wr_fire   = (st_q == DBCC_ACK) && avs_write && hit;
  assign init_fire = wr_fire && (reg_sel == REG_CMD) && avs_writedata[CMD_INIT_BIT];
  assign sw_fire   = wr_fire && (reg_sel == REG_CMD) && avs_writedata[CMD_SW_BIT];
  assign sw_state  = avs_writedata[CMD_STATE_BIT];

  assign core.bit_valid = wr_fire && (reg_sel == REG_SHIFT);
  assign core.bit_in    = avs_writedata[SH_DATA_BIT];
  assign core.bit_ch    = avs_writedata[SH_CH_LSB +: CH_W];
  assign core.abort     = init_fire;
  assign core.cal_idx   = cal_idx_q[CH_W-1:0];
  assign core.cal_wdata = avs_writedata[CAL_W-1:0];
  assign core.cal_we    = wr_fire && (reg_sel == REG_CAL_DATA) &&
                          dbcc_cal_local(cal_idx_q, board_sel);

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cal_idx_q <= CAL_IDX_RST;
    end else if (wr_fire && (reg_sel == REG_CAL_IDX)) begin
      cal_idx_q <= avs_writedata[CAL_IDX_W-1:0];
    end
  end

  dbcc_shifter u_shifter (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .sif     (core.shift)
  );

  dbcc_calib u_calib (
    .ref_clk (ref_clk),
    .por_n   (por_n),
    .cif     (core.cal)
  );

  // ****************************************************************
  // Analog state
  // ****************************************************************
  // Only power-on resets this state, so a bus reset leaves every level alone.
  assign load_ok = core.load && !(four_ch_variant && core.load_ch[CH_W-1]);

  always_ff @(posedge ref_clk) begin
    if (!por_n) begin
      ref_q <= 1'b0;
    end else if (sw_fire) begin
      ref_q <= sw_state;
    end else if (init_fire) begin
      ref_q <= 1'b0;
    end
  end

  // Switching either way turns every converter off at once.
  always_ff @(posedge ref_clk) begin
    if (!por_n) begin
      en_q <= EN_RST;
    end else if (init_fire || sw_fire) begin
      en_q <= EN_RST;
    end else if (load_ok) begin
      en_q[core.load_ch] <= 1'b1;
    end
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    always_ff @(posedge ref_clk) begin
      if (!por_n) begin
        code_q[i] <= CODE_RST;
      end else if (load_ok && (core.load_ch == CH_W'(i))) begin
        code_q[i] <= core.load_code;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (!por_n) begin
        level_q[i] <= CODE_RST;
      end else begin
        level_q[i] <= (en_q[i] && ref_q) ? code_q[i] : CODE_RST;
      end
    end
  end

  assign dac_code   = code_q;
  assign dac_out_en = en_q;
  assign ref_on     = ref_q;
  assign chan_level = level_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  logic [NUM_CH-1:0] live_past_q;
  logic [NUM_CH-1:0] lvl_nz;

  always_ff @(posedge ref_clk) begin
    live_past_q <= en_q & {NUM_CH{ref_q}};
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_nz
    assign lvl_nz[i] = |level_q[i];
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst || !por_n);

  a_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest
                                 |=> !avs_waitrequest)
    else $error("Bus access not answered after one cycle.");

  a_bus_reset_hold: assert property (@(posedge ref_clk) disable iff (!por_n)
    !nrst |=> $stable(dac_code) && $stable(dac_out_en) && $stable(ref_on))
    else $error("Bus reset disturbed the analog state.");

  a_init_tristate: assert property (init_fire && !sw_fire |=>
    dac_out_en == EN_RST && !ref_on)
    else $error("Initialisation left a converter enabled.");

  a_switch_ref: assert property (sw_fire |=> ref_on == $past(sw_state))
    else $error("Reference does not follow the switch state.");

  a_switch_all: assert property (sw_fire |=> dac_out_en == EN_RST)
    else $error("Switch command left some channel enabled.");

  a_switch_on_off: assert property (sw_fire && sw_state |=>
    ref_on && (dac_out_en == EN_RST) ##1 (chan_level == '0))
    else $error("Converters not off while reference turns on.");

  a_first_enable: assert property (load_ok |=> dac_out_en[$past(core.load_ch)])
    else $error("Loaded channel was not enabled.");

  a_off_zero: assert property (##1 (lvl_nz & ~live_past_q) == EN_RST)
    else $error("A switched-off channel shows a nonzero level.");

  a_code_load: assert property (load_ok |=>
    dac_code[$past(core.load_ch)] == $past(core.load_code))
    else $error("Loaded code did not reach the output register.");

  a_shift_order: assert property (core.bit_valid && core.fill_cnt == CNT_LAST && !init_fire
    |=> core.load && core.load_code[0] == $past(core.bit_in))
    else $error("Twelfth bit did not complete the code.");

  a_partial_hold: assert property (!load_ok |=> $stable(dac_code))
    else $error("Output register changed without a complete code.");

  a_cal_board: assert property (core.cal_we |-> cal_idx_q[5:3] == board_sel)
    else $error("Calibration write for a foreign board.");

  a_cal_store: assert property (core.cal_we |=>
    core.cal_rdata == $past(core.cal_wdata))
    else $error("Calibration record not stored.");

  a_decode: assert property (wr_fire |-> avs_address[11:5] == BOARD_PATTERN &&
    avs_address[4:2] == board_sel)
    else $error("Write accepted at a foreign address.");

  // A quiet bus must never stall, or a host polling another board would hang.
  a_idle_ready: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("Waitrequest raised without a request.");

  a_read_unmapped: assert property ((st_q == DBCC_IDLE) && avs_read && !hit
    |=> avs_readdata == RDATA_RST)
    else $error("Foreign read returned nonzero data.");

  a_four_ignore: assert property (core.load && four_ch_variant && core.load_ch[CH_W-1] &&
    !init_fire && !sw_fire |=> $stable(dac_out_en))
    else $error("Four channel board enabled a missing channel.");

  a_abort_clear: assert property (init_fire |=> core.fill_cnt == CNT_RST)
    else $error("Initialisation kept partial shift bits.");

  // The bus reset is checked with power-on only, since the default disable hides it.
  a_nrst_count: assert property (@(posedge ref_clk) disable iff (!por_n)
    !nrst |=> core.fill_cnt == CNT_RST)
    else $error("Bus reset left a partial shift count.");

  c_init:   cover property (init_fire);
  c_ref_on: cover property (sw_fire && sw_state);
  c_load:   cover property (load_ok ##[1:40] load_ok);
  c_cal:    cover property (core.cal_we ##[2:20] (st_q == DBCC_ACK && avs_read));
  c_bus_rst: cover property (@(posedge ref_clk) disable iff (!por_n) !nrst ##1 nrst);
endmodule

`default_nettype wire

/* dbcc_host.sv */
`default_nettype none

// ****************************************************************
// Host controller model on the expansion bus
// ****************************************************************
module dbcc_host (
  input  wire logic                        ref_clk,
  input  wire logic                        avs_waitrequest,
  input  wire logic [dbcc_pkg::DATA_W-1:0] avs_readdata,
  output var  logic [dbcc_pkg::ADDR_W-1:0] avs_address,
  output var  logic                        avs_read,
  output var  logic                        avs_write,
  output var  logic [dbcc_pkg::DATA_W-1:0] avs_writedata
);
  timeunit 1ns;
  timeprecision 1ps;
  import dbcc_pkg::*;

  initial begin
    avs_address   = '0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = '0;
  end

  // One access, entered just after a rising edge; it returns one edge after release.
  // Released address and data lines show the inverse of the last value, so stale data is never mistaken.
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                     output logic [DATA_W-1:0] r);
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) @(posedge ref_clk);
    r = avs_readdata;
    avs_read      <= 1'b0;
    avs_write     <= 1'b0;
    avs_address   <= ~a;
    avs_writedata <= ~d;
    @(posedge ref_clk);
  endtask
endmodule

`default_nettype wire

/* tb_dac_board_channel_control.sv */
`default_nettype none

module tb_dac_board_channel_control;
  timeunit 1ns;
  timeprecision 1ps;
  import dbcc_pkg::*;

  logic                          ref_clk, nrst, por_n, four_ch_variant;
  logic [CH_W-1:0]               board;
  logic [ADDR_W-1:0]             avs_address;
  logic                          avs_read, avs_write, avs_waitrequest, ref_on;
  logic [DATA_W-1:0]             avs_writedata, avs_readdata;
  logic [NUM_CH-1:0][CODE_W-1:0] dac_code, chan_level;
  logic [NUM_CH-1:0]             dac_out_en;
  int                            n_fail, cmp_count, exp_ref, four;
  int                            exp_code[8];
  int                            exp_en[8];
  int                            cal_m[64];
  int                            idxs[$];

  dbcc_top u_dbcc_top (.ref_clk(ref_clk), .nrst(nrst), .por_n(por_n), .board_sel(board),
    .four_ch_variant(four_ch_variant), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .dac_code(dac_code), .dac_out_en(dac_out_en),
    .ref_on(ref_on), .chan_level(chan_level));

  dbcc_host u_dbcc_host (.ref_clk(ref_clk), .avs_waitrequest(avs_waitrequest),
    .avs_readdata(avs_readdata), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata));

  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // ****************************************************************
  // Bus tasks and reference model
  // ****************************************************************
  function automatic logic [ADDR_W-1:0] adr(input logic [1:0] rr);
    return {BOARD_PATTERN, board, rr};
  endfunction

  task automatic wr(input logic [1:0] rr, input logic [31:0] d);
    logic [31:0] r;
    u_dbcc_host.acc(1'b1, adr(rr), d, r);
  endtask

  task automatic rd(input logic [1:0] rr, output logic [31:0] r);
    u_dbcc_host.acc(1'b0, adr(rr), 32'h0, r);
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [31:0] cmd_exp();
    logic [7:0] ev;
    for (int i = 0; i < 8; i++) ev[i] = exp_en[i][0];
    return {22'h0, 1'(four), 1'(exp_ref), ev};
  endfunction

  task automatic cmd(input logic [2:0] c);
    wr(REG_CMD, {29'h0, c});
    if (c[CMD_INIT_BIT] || c[CMD_SW_BIT]) foreach (exp_en[i]) exp_en[i] = 0;
    if (c[CMD_INIT_BIT]) exp_ref = 0;
    if (c[CMD_SW_BIT]) exp_ref = int'(c[CMD_STATE_BIT]);
  endtask

  // Bits go out most significant first; the channel rides along with every bit.
  task automatic load(input int ch, input logic [11:0] code, input int nb);
    for (int i = 0; i < nb; i++) wr(REG_SHIFT, {28'h0, 3'(ch), code[11-i]});
    if (nb == 12 && !(four != 0 && ch > 3)) begin
      exp_code[ch] = int'(code);
      exp_en[ch] = 1;
    end
  endtask

  task automatic chk_outs();
    logic [31:0] r;
    repeat (2) @(posedge ref_clk);
    #1;
    for (int i = 0; i < NUM_CH; i++) begin
      chk("dac_code", 32'(exp_code[i]), {20'h0, dac_code[i]});
      chk("chan_level", (exp_en[i] != 0 && exp_ref != 0) ? 32'(exp_code[i]) : 32'h0,
          {20'h0, chan_level[i]});
      chk("dac_out_en", 32'(exp_en[i]), {31'h0, dac_out_en[i]});
    end
    chk("ref_on", 32'(exp_ref), {31'h0, ref_on});
    @(posedge ref_clk);
    rd(REG_CMD, r);
    chk("cmd_read", cmd_exp(), r);
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    $display("unexpected watchdog expected done seen hang");
    report_and_stop();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    logic [31:0] r;
    logic [11:0] c;
    int          idx;
    void'($urandom(61700));
    board = 3'($urandom);
    four = 0;
    four_ch_variant = 1'b0;
    nrst = 1'b0;
    por_n = 1'b0;
    exp_ref = 0;
    foreach (exp_code[i]) exp_code[i] = 0;
    foreach (exp_en[i]) exp_en[i] = 0;
    foreach (cal_m[i]) cal_m[i] = 0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    por_n <= 1'b1;
    // The long settling wait after bus reset is shortened to a few cycles.
    repeat (3) @(posedge ref_clk);
    chk_outs();
    $display("test power up done");
    cmd(3'h6);
    load(0, 12'hfff, 11);
    rd(REG_SHIFT, r);
    chk("fill_count", 32'hb, r & 32'hf);
    chk_outs();
    cmd(3'h1);
    rd(REG_SHIFT, r);
    chk("fill_count", 32'h0, r & 32'hf);
    chk_outs();
    $display("test partial shift done");
    cmd(3'h6);
    chk_outs();
    for (int ch = 0; ch < NUM_CH; ch++) begin
      c = 12'($urandom);
      load(ch, c, 12);
      chk_outs();
    end
    load(3, 12'hfff, 12);
    load(4, 12'h000, 12);
    rd(REG_SHIFT, r);
    chk("shift_read", 32'h40, r);
    chk_outs();
    $display("test channel loads done");
    load(1, 12'($urandom), 5);
    nrst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    chk_outs();
    load(1, 12'($urandom), 12);
    chk_outs();
    $display("test bus reset done");
    cmd(3'h2);
    chk_outs();
    load(2, 12'($urandom), 12);
    chk_outs();
    cmd(3'h7);
    chk_outs();
    $display("test switch done");
    four_ch_variant <= 1'b1;
    four = 1;
    @(posedge ref_clk);
    load(5, 12'($urandom), 12);
    load(2, 12'($urandom), 12);
    chk_outs();
    $display("test four channel done");
    for (int k = 0; k < 2; k++) begin
      u_dbcc_host.acc(1'b1, k == 0 ? {BOARD_PATTERN, board + 3'h1, REG_CMD} : 12'h000,
                      32'h1, r);
      u_dbcc_host.acc(1'b0, k == 0 ? {BOARD_PATTERN, board + 3'h1, REG_CMD} : 12'h000,
                      32'h0, r);
      chk("unmapped_read", 32'h0, r);
    end
    chk_outs();
    $display("test unmapped done");
    for (int k = 0; k < 4; k++) begin
      idx = (k < 3) ? 8 * int'(board) + 3 * k : 8 * ((int'(board) + 1) % 8) + k;
      idxs.push_back(idx);
      r = 32'($urandom) & 32'hffff;
      wr(REG_CAL_IDX, 32'(idx));
      wr(REG_CAL_DATA, r);
      if (k < 3) cal_m[idx] = int'(r);
    end
    for (int p = 0; p < 2; p++) begin
      foreach (idxs[k]) begin
        wr(REG_CAL_IDX, 32'(idxs[k]));
        rd(REG_CAL_IDX, r);
        chk("cal_index", 32'(idxs[k]), r);
        rd(REG_CAL_DATA, r);
        chk("cal_record", 32'(cal_m[idxs[k]]), r);
      end
      por_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      por_n <= 1'b1;
      exp_ref = 0;
      foreach (exp_code[i]) exp_code[i] = 0;
      foreach (exp_en[i]) exp_en[i] = 0;
      foreach (cal_m[i]) cal_m[i] = 0;
      chk_outs();
    end
    $display("test calibration done");
    report_and_stop();
  end
endmodule

`default_nettype wire
